// >>> pigp_cfg.svh
`ifndef PIGP_CFG_SVH
`define PIGP_CFG_SVH

// bus geometry
`define PIGP_ADDR_W 12
`define PIGP_BUS_W 32
`define PIGP_PORT_W 8
`define PIGP_IDX_W 10

// register indices; byte address is four times the index
`define PIGP_IDX_P_DATA 10'h258
`define PIGP_IDX_P_PIN 10'h259
`define PIGP_IDX_P_DIR 10'h25A
`define PIGP_IDX_P_PULL_EN 10'h25C
`define PIGP_IDX_P_PULL_POL 10'h25D
`define PIGP_IDX_P_IRQ_EN 10'h25E
`define PIGP_IDX_P_IRQ_FLAG 10'h25F
`define PIGP_IDX_J_DATA 10'h268
`define PIGP_IDX_J_PIN 10'h269
`define PIGP_IDX_J_DIR 10'h26A
`define PIGP_IDX_T_DATA 10'h240
`define PIGP_IDX_T_PIN 10'h241
`define PIGP_IDX_T_DIR 10'h242
`define PIGP_IDX_AN_ROUTE 10'h270
`define PIGP_IDX_AD_PULL_EN 10'h271

// field positions
`define PIGP_AN_ROUTE_BIT 0

// reset values
`define PIGP_RST_BYTE 8'h00
`define PIGP_RST_ROUTE 1'h0

// analog channels that follow the routing bit
`define PIGP_AN_CH_N 5

`endif

// >>> pigp_pkg.sv
package pigp_pkg;

  typedef logic [7:0] pigp_byte_t;

  // bus answer sequencer, one-hot
  typedef enum logic [1:0] {
    PIGP_BUS_IDLE = 2'b01,
    PIGP_BUS_ANSWER = 2'b10
  } pigp_bus_state_t;

endpackage

// >>> pigp_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "pigp_cfg.svh"

module pigp_port #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register writes
  input wire logic [W-1:0] wdata,
  input wire logic wr_data,
  input wire logic wr_dir,
  // pins and alternative functions
  input wire logic [W-1:0] pin_in,
  input wire logic [W-1:0] alt_claim,
  input wire logic [W-1:0] alt_out,
  input wire logic [W-1:0] alt_oe,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe,
  // register state
  output logic [W-1:0] data_q,
  output logic [W-1:0] dir_q,
  output logic [W-1:0] pin_sync,
  output logic [W-1:0] rd_data
);

  logic [W-1:0] meta_q;

  if (W < 1 || W > 8) begin : g_chk
    $error("pigp_port: width must be 1 to 8");
  end

  ////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      data_q <= W'(`PIGP_RST_BYTE);
    end else if (wr_data) begin
      data_q <= wdata;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dir_q <= W'(`PIGP_RST_BYTE);
    end else if (wr_dir) begin
      dir_q <= wdata;
    end
  end

  // pins are asynchronous to the core clock
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      pin_sync <= '0;
    end else begin
      meta_q <= pin_in;
      pin_sync <= meta_q;
    end
  end

  ////////////////////////////////////////////////////////////
  // a claimed pin belongs to its peripheral, otherwise gpio
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (alt_claim[i]) begin
        pin_out[i] = alt_out[i];
        pin_oe[i] = alt_oe[i];
      end else begin
        pin_out[i] = data_q[i];
        pin_oe[i] = dir_q[i];
      end
    end
  end

  assign rd_data = (dir_q & data_q) | (~dir_q & pin_sync);

endmodule // pigp_port

`default_nettype wire

// >>> pigp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pigp_cfg.svh"

// Behaviour
// - unmapped addresses read zero, and writes there change nothing.
// - an unclaimed pin is plain gpio steered by its port registers.
// - in output mode the pin is driven from the data register bit.
// - data reads return the register bit when output, else the synced pin.
// - data registers are writable at any time; reads return them only on output bits.
// - route bit 0 links channels 10,11,13,14,15 to the analog port pins.
// - route bit 1 links those channels to alternate port pins 0 to 4.
// - port p pull enable acts on input pins only, polarity from its select bit.
module pigp_top #(
  parameter int PORT_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [`PIGP_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [`PIGP_BUS_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [`PIGP_BUS_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // port p pins
  input wire logic [PORT_W-1:0] pp_pin_in,
  output logic [PORT_W-1:0] pp_pin_out,
  output logic [PORT_W-1:0] pp_pin_oe,
  input wire logic [PORT_W-1:0] pp_alt_claim,
  input wire logic [PORT_W-1:0] pp_alt_out,
  input wire logic [PORT_W-1:0] pp_alt_oe,
  output logic [PORT_W-1:0] pp_pull_en,
  output logic [PORT_W-1:0] pp_pull_up,
  // port j pins
  input wire logic [PORT_W-1:0] pj_pin_in,
  output logic [PORT_W-1:0] pj_pin_out,
  output logic [PORT_W-1:0] pj_pin_oe,
  input wire logic [PORT_W-1:0] pj_alt_claim,
  input wire logic [PORT_W-1:0] pj_alt_out,
  input wire logic [PORT_W-1:0] pj_alt_oe,
  // port t pins
  input wire logic [PORT_W-1:0] pt_pin_in,
  output logic [PORT_W-1:0] pt_pin_out,
  output logic [PORT_W-1:0] pt_pin_oe,
  input wire logic [PORT_W-1:0] pt_alt_claim,
  input wire logic [PORT_W-1:0] pt_alt_out,
  input wire logic [PORT_W-1:0] pt_alt_oe,
  // analog routing
  output logic [`PIGP_AN_CH_N-1:0] ad_analog_link,
  output logic [`PIGP_AN_CH_N-1:0] alt_analog_link,
  output logic [PORT_W-1:0] ad_pull_en
);

  if (PORT_W != 8) begin : g_chk
    $error("pigp_top: ports are eight bits wide");
  end

  ////////////////////////////////////////////////////////////
  // bus sequencer

  pigp_pkg::pigp_bus_state_t bus_state_q;
  pigp_pkg::pigp_bus_state_t bus_state_d;
  logic bus_req;
  logic take;
  logic wr_go;
  logic lane0;
  logic [`PIGP_IDX_W-1:0] idx;
  pigp_pkg::pigp_byte_t wbyte;
  pigp_pkg::pigp_byte_t rd_mux;
  logic [`PIGP_BUS_W-1:0] readdata_q;

  assign bus_req = avs_read | avs_write;
  assign idx = avs_address[`PIGP_ADDR_W-1:2];
  assign wbyte = avs_writedata[7:0];
  assign lane0 = avs_byteenable[0];

  // one wait cycle gives the read mux a full clock to settle
  assign take = bus_req && (bus_state_q == pigp_pkg::PIGP_BUS_IDLE);
  assign wr_go = avs_write && lane0
    && (bus_state_q == pigp_pkg::PIGP_BUS_ANSWER);
  assign avs_waitrequest = take;
  assign avs_readdata = readdata_q;

  always_comb begin
    bus_state_d = bus_state_q;
    unique case (bus_state_q)
      pigp_pkg::PIGP_BUS_IDLE: begin
        if (bus_req) begin
          bus_state_d = pigp_pkg::PIGP_BUS_ANSWER;
        end
      end
      pigp_pkg::PIGP_BUS_ANSWER: begin
        bus_state_d = pigp_pkg::PIGP_BUS_IDLE;
      end
      default: begin
        bus_state_d = pigp_pkg::PIGP_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bus_state_q <= pigp_pkg::PIGP_BUS_IDLE;
    end else begin
      bus_state_q <= bus_state_d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      readdata_q <= 32'h00000000;
    end else if (take && avs_read) begin
      readdata_q <= {24'h000000, rd_mux};
    end
  end

  ////////////////////////////////////////////////////////////
  // write strobes

  logic wr_p_data;
  logic wr_p_dir;
  logic wr_p_pull_en;
  logic wr_p_pull_pol;
  logic wr_p_irq_en;
  logic wr_p_irq_flag;
  logic wr_j_data;
  logic wr_j_dir;
  logic wr_t_data;
  logic wr_t_dir;
  logic wr_route;
  logic wr_ad_pull;

  // pin input registers get no strobe, so writes there fall away
  assign wr_p_data = wr_go && (idx == `PIGP_IDX_P_DATA);
  assign wr_p_dir = wr_go && (idx == `PIGP_IDX_P_DIR);
  assign wr_p_pull_en = wr_go && (idx == `PIGP_IDX_P_PULL_EN);
  assign wr_p_pull_pol = wr_go && (idx == `PIGP_IDX_P_PULL_POL);
  assign wr_p_irq_en = wr_go && (idx == `PIGP_IDX_P_IRQ_EN);
  assign wr_p_irq_flag = wr_go && (idx == `PIGP_IDX_P_IRQ_FLAG);
  assign wr_j_data = wr_go && (idx == `PIGP_IDX_J_DATA);
  assign wr_j_dir = wr_go && (idx == `PIGP_IDX_J_DIR);
  assign wr_t_data = wr_go && (idx == `PIGP_IDX_T_DATA);
  assign wr_t_dir = wr_go && (idx == `PIGP_IDX_T_DIR);
  assign wr_route = wr_go && (idx == `PIGP_IDX_AN_ROUTE);
  assign wr_ad_pull = wr_go && (idx == `PIGP_IDX_AD_PULL_EN);

  ////////////////////////////////////////////////////////////
  // the three gpio ports

  pigp_pkg::pigp_byte_t p_data_q;
  pigp_pkg::pigp_byte_t p_dir_q;
  pigp_pkg::pigp_byte_t p_sync;
  pigp_pkg::pigp_byte_t p_rd;
  pigp_pkg::pigp_byte_t j_data_q;
  pigp_pkg::pigp_byte_t j_dir_q;
  pigp_pkg::pigp_byte_t j_sync;
  pigp_pkg::pigp_byte_t j_rd;
  pigp_pkg::pigp_byte_t t_data_q;
  pigp_pkg::pigp_byte_t t_dir_q;
  pigp_pkg::pigp_byte_t t_sync;
  pigp_pkg::pigp_byte_t t_rd;

  pigp_port #(
    .W(PORT_W)
  ) u_port_p (
    .core_clk(core_clk),
    .resetn(resetn),
    .wdata(wbyte),
    .wr_data(wr_p_data),
    .wr_dir(wr_p_dir),
    .pin_in(pp_pin_in),
    .alt_claim(pp_alt_claim),
    .alt_out(pp_alt_out),
    .alt_oe(pp_alt_oe),
    .pin_out(pp_pin_out),
    .pin_oe(pp_pin_oe),
    .data_q(p_data_q),
    .dir_q(p_dir_q),
    .pin_sync(p_sync),
    .rd_data(p_rd)
  );

  pigp_port #(
    .W(PORT_W)
  ) u_port_j (
    .core_clk(core_clk),
    .resetn(resetn),
    .wdata(wbyte),
    .wr_data(wr_j_data),
    .wr_dir(wr_j_dir),
    .pin_in(pj_pin_in),
    .alt_claim(pj_alt_claim),
    .alt_out(pj_alt_out),
    .alt_oe(pj_alt_oe),
    .pin_out(pj_pin_out),
    .pin_oe(pj_pin_oe),
    .data_q(j_data_q),
    .dir_q(j_dir_q),
    .pin_sync(j_sync),
    .rd_data(j_rd)
  );

  pigp_port #(
    .W(PORT_W)
  ) u_port_t (
    .core_clk(core_clk),
    .resetn(resetn),
    .wdata(wbyte),
    .wr_data(wr_t_data),
    .wr_dir(wr_t_dir),
    .pin_in(pt_pin_in),
    .alt_claim(pt_alt_claim),
    .alt_out(pt_alt_out),
    .alt_oe(pt_alt_oe),
    .pin_out(pt_pin_out),
    .pin_oe(pt_pin_oe),
    .data_q(t_data_q),
    .dir_q(t_dir_q),
    .pin_sync(t_sync),
    .rd_data(t_rd)
  );

  ////////////////////////////////////////////////////////////
  // port p pulls

  pigp_pkg::pigp_byte_t p_pull_en_q;
  pigp_pkg::pigp_byte_t p_pull_pol_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      p_pull_en_q <= `PIGP_RST_BYTE;
    end else if (wr_p_pull_en) begin
      p_pull_en_q <= wbyte;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      p_pull_pol_q <= `PIGP_RST_BYTE;
    end else if (wr_p_pull_pol) begin
      p_pull_pol_q <= wbyte;
    end
  end

  // a driven pin never gets a pull, whoever drives it
  assign pp_pull_en = p_pull_en_q & ~pp_pin_oe;
  assign pp_pull_up = p_pull_pol_q;

  ////////////////////////////////////////////////////////////
  // port p edge flags

  pigp_pkg::pigp_byte_t p_irq_en_q;
  pigp_pkg::pigp_byte_t p_irq_flag_q;
  pigp_pkg::pigp_byte_t p_last_q;
  pigp_pkg::pigp_byte_t p_edge;
  pigp_pkg::pigp_byte_t p_clr;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      p_irq_en_q <= `PIGP_RST_BYTE;
    end else if (wr_p_irq_en) begin
      p_irq_en_q <= wbyte;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      p_last_q <= `PIGP_RST_BYTE;
    end else begin
      p_last_q <= p_sync;
    end
  end

  // pull-up polarity watches rising edges, pull-down falling ones
  assign p_edge = (p_pull_pol_q & p_sync & ~p_last_q)
    | (~p_pull_pol_q & ~p_sync & p_last_q);
  assign p_clr = wr_p_irq_flag ? wbyte : `PIGP_RST_BYTE;

  // write one clears; a new edge in the same cycle wins
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      p_irq_flag_q <= `PIGP_RST_BYTE;
    end else begin
      p_irq_flag_q <= (p_irq_flag_q & ~p_clr) | p_edge;
    end
  end

  ////////////////////////////////////////////////////////////
  // analog routing and analog port pulls

  logic route_q;
  pigp_pkg::pigp_byte_t ad_pull_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      route_q <= `PIGP_RST_ROUTE;
    end else if (wr_route) begin
      route_q <= wbyte[`PIGP_AN_ROUTE_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ad_pull_q <= `PIGP_RST_BYTE;
    end else if (wr_ad_pull) begin
      ad_pull_q <= wbyte;
    end
  end

  // exactly one of the two paths is closed at any time
  assign ad_analog_link = {`PIGP_AN_CH_N{~route_q}};
  assign alt_analog_link = {`PIGP_AN_CH_N{route_q}};
  assign ad_pull_en = ad_pull_q;

  ////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    case (idx)
      `PIGP_IDX_P_DATA: rd_mux = p_rd;
      `PIGP_IDX_P_PIN: rd_mux = p_sync;
      `PIGP_IDX_P_DIR: rd_mux = p_dir_q;
      `PIGP_IDX_P_PULL_EN: rd_mux = p_pull_en_q;
      `PIGP_IDX_P_PULL_POL: rd_mux = p_pull_pol_q;
      `PIGP_IDX_P_IRQ_EN: rd_mux = p_irq_en_q;
      `PIGP_IDX_P_IRQ_FLAG: rd_mux = p_irq_flag_q;
      `PIGP_IDX_J_DATA: rd_mux = j_rd;
      `PIGP_IDX_J_PIN: rd_mux = j_sync;
      `PIGP_IDX_J_DIR: rd_mux = j_dir_q;
      `PIGP_IDX_T_DATA: rd_mux = t_rd;
      `PIGP_IDX_T_PIN: rd_mux = t_sync;
      `PIGP_IDX_T_DIR: rd_mux = t_dir_q;
      `PIGP_IDX_AN_ROUTE: rd_mux = {7'h00, route_q};
      `PIGP_IDX_AD_PULL_EN: rd_mux = ad_pull_q;
      default: rd_mux = `PIGP_RST_BYTE;
    endcase
  end

  // data register outputs of p, j and t are unused here; each port uses them itself
  logic unused_ok;
  assign unused_ok = ^{j_data_q, t_data_q, p_data_q,
    avs_writedata[31:8], avs_byteenable[3:1], avs_address[1:0]};

endmodule // pigp_top

`default_nettype wire

// >>> pigp_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module pigp_pins_model (
  // port drive
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pull_en,
  input wire logic [7:0] pull_up,
  // board level where floating
  input wire logic [7:0] ext,
  output logic [7:0] pin_in
);
  // a pull only matters where nobody drives the pin
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (pull_en[i] ? pull_up[i] : ext[i]);
    end
  end
endmodule // pigp_pins_model
`default_nettype wire

// >>> pigp_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "pigp_cfg.svh"
module pigp_top_checker #(
  parameter int PORT_W = 8
) (
  // bus
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [`PIGP_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [`PIGP_BUS_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [`PIGP_BUS_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // pins
  input wire logic [PORT_W-1:0] pp_pin_out,
  input wire logic [PORT_W-1:0] pp_pin_oe,
  input wire logic [PORT_W-1:0] pp_alt_claim,
  input wire logic [PORT_W-1:0] pp_alt_out,
  input wire logic [PORT_W-1:0] pp_alt_oe,
  input wire logic [PORT_W-1:0] pp_pull_en,
  input wire logic [`PIGP_AN_CH_N-1:0] ad_analog_link,
  input wire logic [`PIGP_AN_CH_N-1:0] alt_analog_link
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire logic req = avs_read | avs_write;
  wire logic done = req & ~avs_waitrequest;
  wire logic [9:0] idx = avs_address[11:2];
  wire logic wr0 = done & avs_write & avs_byteenable[0];
  wire logic rt = wr0 && idx == `PIGP_IDX_AN_ROUTE;
  ////////////////////////////////////////
  a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest) else $error("no wait cycle");
  a_wait_one: assert property (req && avs_waitrequest |=> done) else $error("answer late");
  a_unmapped_zero: assert property (done && avs_read && idx < 10'h240 |-> avs_readdata == 0)
    else $error("unmapped read not zero");
  a_data_drive: assert property (wr0 && idx == `PIGP_IDX_P_DATA |=>
    ((pp_pin_out ^ $past(avs_writedata[7:0])) & ~pp_alt_claim) == 0) else $error("pin not from data");
  a_claim_out: assert property (((pp_pin_out ^ pp_alt_out) & pp_alt_claim) == 0) else $error("claim out");
  a_claim_oe: assert property (((pp_pin_oe ^ pp_alt_oe) & pp_alt_claim) == 0) else $error("claim oe");
  a_pull_gate: assert property ((pp_pull_en & pp_pin_oe) == 0) else $error("pull on output");
  a_route_pair: assert property (ad_analog_link == ~alt_analog_link) else $error("route overlap");
  a_route_write: assert property (rt |=> alt_analog_link == {5{$past(avs_writedata[0])}})
    else $error("route write");
  a_route_hold: assert property (!rt |=> $stable(alt_analog_link)) else $error("route moved");
  c_read: cover property (done && avs_read);
  c_route: cover property (rt);
  c_pull: cover property (pp_pull_en != 0);
endmodule // pigp_top_checker
bind pigp_top pigp_top_checker #(.PORT_W(PORT_W)) u_chk (.core_clk(core_clk), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pp_pin_out(pp_pin_out), .pp_pin_oe(pp_pin_oe), .pp_alt_claim(pp_alt_claim), .pp_alt_out(pp_alt_out),
  .pp_alt_oe(pp_alt_oe), .pp_pull_en(pp_pull_en), .ad_analog_link(ad_analog_link),
  .alt_analog_link(alt_analog_link));
`default_nettype wire

// >>> pigp_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pigp_cfg.svh"
module pigp_top_bench;
  logic core_clk, resetn, avs_read, avs_write;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest;
  logic [7:0] ext [3], cl [3], ao [3], ae [3], dt [3], dr [3];
  wire logic [7:0] po [3], oe [3], pi [3];
  wire logic [7:0] pull_en, pull_up, ad_pull;
  wire logic [4:0] ad_link, alt_link;
  logic [15:0] lf;
  logic [7:0] q, e;
  int mismatches, checks, p;
  localparam logic [9:0] IDAT [3] = '{`PIGP_IDX_P_DATA, `PIGP_IDX_J_DATA, `PIGP_IDX_T_DATA};
  localparam logic [9:0] IDIR [3] = '{`PIGP_IDX_P_DIR, `PIGP_IDX_J_DIR, `PIGP_IDX_T_DIR};
  localparam logic [9:0] IPIN [3] = '{`PIGP_IDX_P_PIN, `PIGP_IDX_J_PIN, `PIGP_IDX_T_PIN};
  localparam logic [9:0] IZ [9] = '{`PIGP_IDX_P_DIR, `PIGP_IDX_J_DIR, `PIGP_IDX_T_DIR, `PIGP_IDX_P_PULL_EN,
    `PIGP_IDX_P_PULL_POL, `PIGP_IDX_P_IRQ_FLAG, `PIGP_IDX_AN_ROUTE, 10'h25B, 10'h000};
  pigp_top dut (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pp_pin_in(pi[0]), .pp_pin_out(po[0]), .pp_pin_oe(oe[0]), .pp_alt_claim(cl[0]), .pp_alt_out(ao[0]),
    .pp_alt_oe(ae[0]), .pp_pull_en(pull_en), .pp_pull_up(pull_up),
    .pj_pin_in(pi[1]), .pj_pin_out(po[1]), .pj_pin_oe(oe[1]), .pj_alt_claim(cl[1]), .pj_alt_out(ao[1]),
    .pj_alt_oe(ae[1]), .pt_pin_in(pi[2]), .pt_pin_out(po[2]), .pt_pin_oe(oe[2]), .pt_alt_claim(cl[2]),
    .pt_alt_out(ao[2]), .pt_alt_oe(ae[2]), .ad_analog_link(ad_link), .alt_analog_link(alt_link),
    .ad_pull_en(ad_pull));
  pigp_pins_model m0 (.pin_out(po[0]), .pin_oe(oe[0]), .pull_en(pull_en), .pull_up(pull_up), .ext(ext[0]),
    .pin_in(pi[0]));
  pigp_pins_model m1 (.pin_out(po[1]), .pin_oe(oe[1]), .pull_en(8'h00), .pull_up(8'h00), .ext(ext[1]),
    .pin_in(pi[1]));
  pigp_pins_model m2 (.pin_out(po[2]), .pin_oe(oe[2]), .pull_en(8'h00), .pull_up(8'h00), .ext(ext[2]),
    .pin_in(pi[2]));
  ////////////////////////////////////////
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] mix(input logic [7:0] a, input logic [7:0] b, input logic [7:0] s);
    return (a & s) | (b & ~s);
  endfunction
  task automatic end_sim;
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    checks++;
    if (s !== x) begin
      mismatches++;
      $display("mismatch %0t got %h exp %h", $time, s, x);
    end
  endtask
  // waitrequest and readdata are sampled at the rising edge, before that edge's own updates land
  task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d, input logic [3:0] be);
    int n;
    @(posedge core_clk);
    avs_address <= {i, 2'h0};
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 50);
    if (n >= 50) begin
      mismatches++;
      end_sim();
    end
    q = avs_readdata[7:0];
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  ////////////////////////////////////////
  initial begin
    resetn = 1'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_address = 12'h000;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
    ext = '{default: 8'h00};
    cl = '{default: 8'h00};
    ao = '{default: 8'h00};
    ae = '{default: 8'h00};
    mismatches = 0;
    checks = 0;
    lf = 16'hC986;
    repeat (2) @(posedge core_clk);
    resetn <= 1'h1;
    bus(1'h1, 10'h25B, 8'hFF, 4'h1);
    bus(1'h1, 10'h000, 8'hFF, 4'h1);
    foreach (IZ[i]) begin
      bus(1'h0, IZ[i], 8'h00, 4'h1);
      chk(q, 8'h00);
    end
    chk({3'h0, ad_link}, 8'h1F);
    for (int k = 0; k < 21; k++) begin
      p = k % 3;
      lf = nx(lf);
      ext[p] <= lf[7:0];
      dr[p] = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : lf[15:8];
      lf = nx(lf);
      dt[p] = lf[7:0];
      bus(1'h1, IDIR[p], dr[p], 4'h1);
      bus(1'h1, IDAT[p], dt[p], 4'h1);
      @(negedge core_clk);
      chk(po[p], dt[p]);
      chk(oe[p], dr[p]);
      repeat (3) @(posedge core_clk);
      e = mix(dt[p], ext[p], dr[p]);
      bus(1'h0, IDAT[p], 8'h00, 4'h1);
      chk(q, e);
      bus(1'h1, IPIN[p], ~e, 4'h1);
      bus(1'h0, IPIN[p], 8'h00, 4'h1);
      chk(q, e);
    end
    bus(1'h1, IDIR[0], 8'hFF, 4'h1);
    bus(1'h1, IDAT[0], 8'h3C, 4'h1);
    bus(1'h1, IDAT[0], 8'hC3, 4'hE);
    bus(1'h0, IDAT[0], 8'h00, 4'h1);
    chk(q, 8'h3C);
    dt[0] = 8'h3C;
    dr[0] = 8'h0F;
    bus(1'h1, IDIR[0], 8'h0F, 4'h1);
    bus(1'h1, `PIGP_IDX_P_PULL_EN, 8'hFF, 4'h1);
    bus(1'h1, `PIGP_IDX_P_PULL_POL, 8'hA5, 4'h1);
    @(negedge core_clk);
    chk(pull_en, 8'hF0);
    chk(pull_up, 8'hA5);
    repeat (3) @(posedge core_clk);
    bus(1'h0, IPIN[0], 8'h00, 4'h1);
    chk(q, mix(8'h3C, 8'hA5, 8'h0F));
    for (int k = 0; k < 3; k++) begin
      lf = nx(lf);
      cl[k] <= 8'hF0;
      ao[k] <= lf[7:0];
      ae[k] <= 8'hFF;
      @(negedge core_clk);
      chk(po[k], mix(ao[k], dt[k], 8'hF0));
      chk(oe[k], dr[k] | 8'hF0);
      @(posedge core_clk);
      cl[k] <= 8'h00;
    end
    bus(1'h1, `PIGP_IDX_AN_ROUTE, 8'h01, 4'h1);
    @(negedge core_clk);
    chk({3'h0, alt_link}, 8'h1F);
    chk({3'h0, ad_link}, 8'h00);
    bus(1'h1, `PIGP_IDX_AN_ROUTE, 8'h00, 4'h1);
    @(negedge core_clk);
    chk({3'h0, ad_link}, 8'h1F);
    lf = nx(lf);
    bus(1'h1, `PIGP_IDX_AD_PULL_EN, lf[7:0], 4'h1);
    @(negedge core_clk);
    chk(ad_pull, lf[7:0]);
    bus(1'h1, `PIGP_IDX_P_IRQ_EN, lf[15:8], 4'h1);
    bus(1'h0, `PIGP_IDX_P_IRQ_EN, 8'h00, 4'h1);
    chk(q, lf[15:8]);
    end_sim();
  end
endmodule // pigp_top_bench
`default_nettype wire
